// ---- core/sfwp_pkg.sv ----
// Summary of operation
// - erased array bytes read as FFh
// - status register starts at 00h
// - command engine starts in standby
// - only complete accepted commands change state
// - command length must be whole bytes
// - data changes need write enable latch
// - block protect bits fence off region
// - low write protect freezes every status bit except the complement bit
// - deep power-down honours only release command
// - code zero none, codes six-seven all
// - complement bit inverts protected region
// - 64KB steps protect top or bottom of array
// - 4KB steps protect top of array
// - 4KB steps protect bottom of array
// - overlapping program or erase is ignored
// - select release must fall on byte boundary
package sfwp_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int SELECT_DELAY_US = 70;
	localparam int SELECT_DELAY_CYC = SELECT_DELAY_US * CLK_MHZ;

	// ----------------------------------------
	// reset values and status layout
	// ----------------------------------------
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam int BP_POS = 0;
	localparam int BP_W = 5;
	localparam int CMP_POS = 5;
	localparam int LOCK0_POS = 6;
	localparam int LOCK1_POS = 7;
	localparam logic [7:0] WP_FROZEN_MASK = 8'hDF;

	// ----------------------------------------
	// array geometry
	// ----------------------------------------
	localparam logic [21:0] ARRAY_BYTES = 22'h200000;
	localparam logic [21:0] SIZE_64K = 22'h010000;
	localparam logic [21:0] SIZE_4K = 22'h001000;
	localparam logic [21:0] MASK_PAGE = 22'h0000FF;
	localparam logic [21:0] MASK_SECTOR = 22'h000FFF;
	localparam logic [21:0] MASK_32K = 22'h007FFF;
	localparam logic [21:0] MASK_64K = 22'h00FFFF;
	localparam logic [21:0] MASK_CHIP = 22'h1FFFFF;

	// ----------------------------------------
	// command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_SET_WEL = 8'h06;
	localparam logic [7:0] CMD_CLR_WEL = 8'h04;
	localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
	localparam logic [7:0] CMD_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_ERASE_PAGE = 8'h81;
	localparam logic [7:0] CMD_ERASE_SECTOR = 8'h20;
	localparam logic [7:0] CMD_ERASE_32K = 8'h52;
	localparam logic [7:0] CMD_ERASE_64K = 8'hD8;
	localparam logic [7:0] CMD_ERASE_CHIP = 8'h60;
	localparam logic [7:0] CMD_DEEP_DOWN = 8'hB9;
	localparam logic [7:0] CMD_RELEASE = 8'hAB;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		SFWP_OP_PROGRAM,
		SFWP_OP_ERASE_PAGE,
		SFWP_OP_ERASE_SECTOR,
		SFWP_OP_ERASE_32K,
		SFWP_OP_ERASE_64K,
		SFWP_OP_ERASE_CHIP
	} sfwp_op_type;

	typedef struct packed {
		logic valid;
		sfwp_op_type op;
		logic [23:0] addr;
		logic [7:0] data;
	} sfwp_exec_type;

	typedef struct packed {
		logic valid;
		logic [21:0] lo;
		logic [21:0] hi;
	} sfwp_range_type;

endpackage

// ---- core/sfwp_core.sv ----
`timescale 1ns/10ps
module sfwp_core #(
	parameter int POWER_UP_CYCLES = sfwp_pkg::SELECT_DELAY_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_si_i,
	input wire logic wp_n_i,
	output sfwp_pkg::sfwp_exec_type exec_o,
	output logic [7:0] status_o,
	output logic write_enable_latch_o,
	output logic deep_power_down_o,
	output logic ready_o,
	output logic cmd_reject_o
);

	// ----------------------------------------
	// parameter checks
	// ----------------------------------------
	if (POWER_UP_CYCLES < 1 || POWER_UP_CYCLES > 2047) begin : g_bad_delay
		$error("POWER_UP_CYCLES out of range 1..2047");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_STANDBY,
		ST_FRAME,
		ST_IGNORE
	} sfwp_state_type;

	typedef struct packed {
		sfwp_state_type state;
		logic sclk_s1;
		logic sclk_s2;
		logic sclk_s3;
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		logic si_s1;
		logic si_s2;
		logic wp_s1;
		logic wp_s2;
		logic [10:0] pu_cnt;
		logic pu_done;
		logic [2:0] bit_idx;
		logic [2:0] byte_cnt;
		logic [7:0] shreg;
		logic [7:0] opcode;
		logic [23:0] addr;
		logic [7:0] data;
		logic [7:0] status;
		logic write_enable_latch;
		logic deep;
		logic reject;
		sfwp_pkg::sfwp_exec_type exec;
	} sfwp_regs_type;

	sfwp_regs_type r;
	sfwp_regs_type next_r;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	// expected frame length in bytes; five means five or more
	function automatic logic [2:0] cmd_len(input logic [7:0] code);
		case (code)
			sfwp_pkg::CMD_SET_WEL,
			sfwp_pkg::CMD_CLR_WEL,
			sfwp_pkg::CMD_DEEP_DOWN,
			sfwp_pkg::CMD_RELEASE,
			sfwp_pkg::CMD_ERASE_CHIP: cmd_len = 3'h1;
			sfwp_pkg::CMD_WRITE_STATUS: cmd_len = 3'h2;
			sfwp_pkg::CMD_ERASE_PAGE,
			sfwp_pkg::CMD_ERASE_SECTOR,
			sfwp_pkg::CMD_ERASE_32K,
			sfwp_pkg::CMD_ERASE_64K: cmd_len = 3'h4;
			sfwp_pkg::CMD_PROGRAM: cmd_len = 3'h5;
			default: cmd_len = 3'h0;
		endcase
	endfunction

	function automatic sfwp_pkg::sfwp_op_type cmd_op(input logic [7:0] code);
		case (code)
			sfwp_pkg::CMD_ERASE_PAGE: cmd_op = sfwp_pkg::SFWP_OP_ERASE_PAGE;
			sfwp_pkg::CMD_ERASE_SECTOR: cmd_op = sfwp_pkg::SFWP_OP_ERASE_SECTOR;
			sfwp_pkg::CMD_ERASE_32K: cmd_op = sfwp_pkg::SFWP_OP_ERASE_32K;
			sfwp_pkg::CMD_ERASE_64K: cmd_op = sfwp_pkg::SFWP_OP_ERASE_64K;
			sfwp_pkg::CMD_ERASE_CHIP: cmd_op = sfwp_pkg::SFWP_OP_ERASE_CHIP;
			default: cmd_op = sfwp_pkg::SFWP_OP_PROGRAM;
		endcase
	endfunction

	// span touched by an operation; program is judged by its whole page
	function automatic sfwp_pkg::sfwp_range_type target_range(
		input sfwp_pkg::sfwp_op_type op,
		input logic [23:0] a
	);
		logic [21:0] mask;
		logic [21:0] base;
		mask = sfwp_pkg::MASK_PAGE;
		case (op)
			sfwp_pkg::SFWP_OP_ERASE_SECTOR: mask = sfwp_pkg::MASK_SECTOR;
			sfwp_pkg::SFWP_OP_ERASE_32K: mask = sfwp_pkg::MASK_32K;
			sfwp_pkg::SFWP_OP_ERASE_64K: mask = sfwp_pkg::MASK_64K;
			sfwp_pkg::SFWP_OP_ERASE_CHIP: mask = sfwp_pkg::MASK_CHIP;
			default: mask = sfwp_pkg::MASK_PAGE;
		endcase
		base = {1'b0, a[20:0]};
		target_range.valid = 1'b1;
		target_range.lo = base & ~mask;
		target_range.hi = base | mask;
	endfunction

	// protected bounds from the status byte
	function automatic sfwp_pkg::sfwp_range_type prot_range(input logic [7:0] st);
		logic [4:0] bp;
		logic cmp;
		logic all;
		logic [2:0] sh;
		logic [21:0] size;
		sfwp_pkg::sfwp_range_type base;
		sfwp_pkg::sfwp_range_type res;
		bp = st[sfwp_pkg::BP_POS +: sfwp_pkg::BP_W];
		cmp = st[sfwp_pkg::CMP_POS];
		all = (bp[2:1] == 2'b11);
		sh = (bp[2:0] == 3'h0) ? 3'h0 : bp[2:0] - 3'h1;
		if (bp[4]) begin
			// 32KB tops out the small steps, low code bit ignored
			size = sfwp_pkg::SIZE_4K << (bp[2] ? 3'h3 : sh);
		end else begin
			size = sfwp_pkg::SIZE_64K << sh;
		end
		base.valid = (bp[2:0] != 3'h0);
		if (bp[3]) begin
			base.lo = 22'h000000;
			base.hi = size - 22'h000001;
		end else begin
			base.lo = sfwp_pkg::ARRAY_BYTES - size;
			base.hi = sfwp_pkg::ARRAY_BYTES - 22'h000001;
		end
		if (all) begin
			base.lo = 22'h000000;
			base.hi = sfwp_pkg::ARRAY_BYTES - 22'h000001;
		end
		res = base;
		if (cmp) begin
			res.valid = !all;
			if (!base.valid) begin
				res.lo = 22'h000000;
				res.hi = sfwp_pkg::ARRAY_BYTES - 22'h000001;
			end else if (bp[3]) begin
				res.lo = size;
				res.hi = sfwp_pkg::ARRAY_BYTES - 22'h000001;
			end else begin
				res.lo = 22'h000000;
				res.hi = sfwp_pkg::ARRAY_BYTES - size - 22'h000001;
			end
			res.valid = res.valid | !base.valid;
		end
		prot_range = res;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic sclk_rise;
		logic cs_fall;
		logic cs_rise;
		logic [7:0] byte_in;
		logic length_ok;
		logic hit;
		logic [7:0] keep;
		sfwp_pkg::sfwp_op_type op;
		sfwp_pkg::sfwp_range_type tgt;
		sfwp_pkg::sfwp_range_type prot;
		sclk_rise = 1'b0;
		cs_fall = 1'b0;
		cs_rise = 1'b0;
		byte_in = 8'h00;
		length_ok = 1'b0;
		hit = 1'b0;
		keep = 8'h00;
		op = sfwp_pkg::SFWP_OP_PROGRAM;
		tgt = '0;
		prot = '0;
		next_r = r;
		next_r.reject = 1'b0;
		next_r.exec.valid = 1'b0;

		// data and write protect pins cross in through two flops, clock and select through three
		next_r.sclk_s1 = spi_sclk_i;
		next_r.sclk_s2 = r.sclk_s1;
		next_r.sclk_s3 = r.sclk_s2;
		next_r.cs_s1 = spi_cs_n_i;
		next_r.cs_s2 = r.cs_s1;
		next_r.cs_s3 = r.cs_s2;
		next_r.si_s1 = spi_si_i;
		next_r.si_s2 = r.si_s1;
		next_r.wp_s1 = wp_n_i;
		next_r.wp_s2 = r.wp_s1;
		sclk_rise = r.sclk_s2 & ~r.sclk_s3;
		cs_fall = ~r.cs_s2 & r.cs_s3;
		cs_rise = r.cs_s2 & ~r.cs_s3;

		// guard time after reset, in case the host selects too early
		if (!r.pu_done) begin
			if (r.pu_cnt == 11'(POWER_UP_CYCLES - 1)) begin
				next_r.pu_done = 1'b1;
			end else begin
				next_r.pu_cnt = r.pu_cnt + 11'h001;
			end
		end

		case (r.state)
			ST_STANDBY: begin
				if (cs_fall) begin
					next_r.state = r.pu_done ? ST_FRAME : ST_IGNORE;
					next_r.bit_idx = 3'h0;
					next_r.byte_cnt = 3'h0;
				end
			end
			ST_IGNORE: begin
				if (cs_rise) begin
					next_r.state = ST_STANDBY;
				end
			end
			ST_FRAME: begin
				if (sclk_rise) begin
					byte_in = {r.shreg[6:0], r.si_s2};
					next_r.shreg = byte_in;
					next_r.bit_idx = r.bit_idx + 3'h1;
					if (r.bit_idx == 3'h7) begin
						if (r.byte_cnt != 3'h5) begin
							next_r.byte_cnt = r.byte_cnt + 3'h1;
						end
						case (r.byte_cnt)
							3'h0: next_r.opcode = byte_in;
							3'h1: begin
								next_r.addr[23:16] = byte_in;
								next_r.data = byte_in;
							end
							3'h2: next_r.addr[15:8] = byte_in;
							3'h3: next_r.addr[7:0] = byte_in;
							3'h4: next_r.data = byte_in;
							default: next_r.data = r.data;
						endcase
					end
				end
				if (cs_rise) begin
					next_r.state = ST_STANDBY;
					length_ok = (r.bit_idx == 3'h0) && (cmd_len(r.opcode) != 3'h0)
						&& (r.byte_cnt == cmd_len(r.opcode));
					op = cmd_op(r.opcode);
					tgt = target_range(op, r.addr);
					prot = prot_range(r.status);
					hit = prot.valid && (tgt.lo <= prot.hi) && (tgt.hi >= prot.lo);
					keep = r.wp_s2 ? 8'h00 : sfwp_pkg::WP_FROZEN_MASK;
					if (r.deep) begin
						if (length_ok && r.opcode == sfwp_pkg::CMD_RELEASE) begin
							next_r.deep = 1'b0;
						end else begin
							next_r.reject = 1'b1;
						end
					end else if (!length_ok) begin
						next_r.reject = 1'b1;
					end else begin
						case (r.opcode)
							sfwp_pkg::CMD_SET_WEL: next_r.write_enable_latch = 1'b1;
							sfwp_pkg::CMD_CLR_WEL: next_r.write_enable_latch = 1'b0;
							sfwp_pkg::CMD_DEEP_DOWN: next_r.deep = 1'b1;
							sfwp_pkg::CMD_RELEASE: next_r.deep = 1'b0;
							sfwp_pkg::CMD_WRITE_STATUS: begin
								if (!r.write_enable_latch) begin
									next_r.reject = 1'b1;
								end else begin
									next_r.status = (r.data & ~keep) | (r.status & keep);
									next_r.write_enable_latch = 1'b0;
								end
							end
							default: begin
								if (!r.write_enable_latch) begin
									next_r.reject = 1'b1;
								end else if (hit) begin
									next_r.reject = 1'b1;
								end else begin
									next_r.exec.valid = 1'b1;
									next_r.exec.op = op;
									next_r.exec.addr = r.addr;
									next_r.exec.data = r.data;
									next_r.write_enable_latch = 1'b0;
								end
							end
						endcase
					end
				end
			end
			default: next_r.state = ST_STANDBY;
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			r <= '0;
			r.state <= ST_STANDBY;
			r.sclk_s1 <= 1'b0;
			r.cs_s1 <= 1'b1;
			r.cs_s2 <= 1'b1;
			r.cs_s3 <= 1'b1;
			r.wp_s1 <= 1'b1;
			r.wp_s2 <= 1'b1;
			r.status <= sfwp_pkg::STATUS_RESET;
			r.data <= sfwp_pkg::ERASED_BYTE;
			r.exec.data <= sfwp_pkg::ERASED_BYTE;
			r.exec.op <= sfwp_pkg::SFWP_OP_PROGRAM;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign exec_o = r.exec;
	assign status_o = r.status;
	assign write_enable_latch_o = r.write_enable_latch;
	assign deep_power_down_o = r.deep;
	assign ready_o = r.pu_done;
	assign cmd_reject_o = r.reject;

endmodule

// ---- sim/sfwp_checker.sv ----
`timescale 1ns/10ps
module sfwp_checker #(
	parameter int POWER_UP_CYCLES = 16
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic wp_n_i,
	input sfwp_pkg::sfwp_exec_type exec_o,
	input wire logic [7:0] status_o,
	input wire logic write_enable_latch_o,
	input wire logic deep_power_down_o,
	input wire logic ready_o,
	input wire logic cmd_reject_o
);
	int cyc;
	always_ff @(posedge core_clk_i) cyc <= rst_n_i ? cyc + 1 : 0;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	reset_state_a: assert property ($rose(rst_n_i) |-> status_o == 8'h00 && exec_o.data == 8'hFF &&
		!write_enable_latch_o && !deep_power_down_o && !ready_o) else $error("bad state after reset");
	ready_time_a: assert property ($rose(ready_o) |-> cyc >= POWER_UP_CYCLES - 1 && cyc <= POWER_UP_CYCLES + 2)
		else $error("ready at wrong time");
	exec_wel_a: assert property (exec_o.valid |-> $past(write_enable_latch_o) && !write_enable_latch_o)
		else $error("exec without latch");
	exec_pulse_a: assert property (exec_o.valid |=> !exec_o.valid)
		else $error("exec pulse too long");
	reject_keep_a: assert property (cmd_reject_o |-> $stable(status_o) && $stable(write_enable_latch_o))
		else $error("refused frame changed state");
	early_quiet_a: assert property (!ready_o |-> !exec_o.valid && !cmd_reject_o)
		else $error("activity before ready");
	deep_quiet_a: assert property (deep_power_down_o |=> !exec_o.valid)
		else $error("exec in deep power-down");
	wp_freeze_a: assert property (!wp_n_i && !$past(wp_n_i, 4) |-> (status_o & 8'hDF) == ($past(status_o) & 8'hDF))
		else $error("protect bits changed with pin low");
	protect_all_a: assert property (exec_o.valid |-> !(!status_o[5] && status_o[2:1] == 2'b11) &&
		!(status_o[5] && status_o[2:0] == 3'h0)) else $error("exec in fully protected array");
endmodule
bind sfwp_core sfwp_checker #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) sfwp_checker_i (.core_clk_i(core_clk_i),
	.rst_n_i(rst_n_i), .wp_n_i(wp_n_i), .exec_o(exec_o), .status_o(status_o),
	.write_enable_latch_o(write_enable_latch_o), .deep_power_down_o(deep_power_down_o),
	.ready_o(ready_o), .cmd_reject_o(cmd_reject_o));

// ---- sim/sfwp_host.sv ----
`timescale 1ns/10ps
module sfwp_host (
	input wire logic core_clk_i,
	output logic spi_sclk_o,
	output logic spi_cs_n_o,
	output logic spi_si_o
);
	initial begin
		spi_sclk_o = 1'b0;
		spi_cs_n_o = 1'b1;
		spi_si_o = 1'b0;
	end
	// mode 0, msb first from v[63]; clock stands low between frames
	task automatic send(input logic [63:0] v, input int nbits);
		@(posedge core_clk_i);
		#1 spi_cs_n_o = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			spi_si_o = v[63 - i];
			#160 spi_sclk_o = 1'b1;
			#160 spi_sclk_o = 1'b0;
		end
		#160 spi_cs_n_o = 1'b1;
		spi_si_o = ~spi_si_o;
		#320;
	endtask
endmodule

// ---- sim/sfwp_core_tb.sv ----
`timescale 1ns/10ps
module sfwp_core_tb;
	typedef struct packed {logic rej; logic [2:0] op; logic [23:0] addr; logic [7:0] data; logic chk;} sfwp_note_type;
	logic clk, rst_n, sclk, cs_n, si, wp_n, write_enable_latch, deep, ready, rej;
	sfwp_pkg::sfwp_exec_type exec;
	logic [7:0] status, s;
	logic [23:0] a;
	logic [7:0] ec [5] = '{sfwp_pkg::CMD_ERASE_PAGE, sfwp_pkg::CMD_ERASE_SECTOR, sfwp_pkg::CMD_ERASE_32K,
		sfwp_pkg::CMD_ERASE_64K, sfwp_pkg::CMD_ERASE_CHIP};
	int n_errors, n_compared, seed;
	sfwp_note_type q[$];
	sfwp_note_type n;
	sfwp_core #(.POWER_UP_CYCLES(16)) sfwp_core_i (.core_clk_i(clk), .rst_n_i(rst_n), .spi_sclk_i(sclk),
		.spi_cs_n_i(cs_n), .spi_si_i(si), .wp_n_i(wp_n), .exec_o(exec), .status_o(status),
		.write_enable_latch_o(write_enable_latch), .deep_power_down_o(deep), .ready_o(ready), .cmd_reject_o(rej));
	sfwp_host sfwp_host_i (.core_clk_i(clk), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_si_o(si));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] v);
		n_compared++;
		if (e !== v) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, v);
		end
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// op 7 without refusal means no pulse is due
	task automatic cmd(input logic [63:0] v, input int nb, input logic r, input logic [2:0] op, input logic c);
		if (r || op != 3'h7) q.push_back('{r, op, v[55:32], v[31:24], c});
		sfwp_host_i.send(v, nb);
		repeat (8) @(posedge clk);
		#1;
	endtask
	// protected-region decode; regions are 4KB aligned, so one address speaks for its page
	function automatic logic prot(input logic [7:0] st, input logic [23:0] ad);
		int sz;
		logic in;
		sz = st[4] ? (st[2] ? 32'h8000 : 32'h1000 << (st[1:0] - 2'd1)) : 32'h10000 << (st[2:0] - 3'd1);
		in = st[3] ? ad < sz : ad >= 32'h200000 - sz;
		if (st[2:0] == 3'h0) in = 1'b0;
		if (st[2:1] == 2'b11) in = 1'b1;
		return in ^ st[5];
	endfunction
	// outputs are looked at mid-cycle, well clear of the edge that launches them
	always @(negedge clk) begin
		if (rst_n && (exec.valid || rej)) begin
			if (q.size() == 0) chk("unexpected", 0, 1);
			else begin
				n = q.pop_front();
				chk("reject", n.rej, rej);
				chk("valid", !n.rej, exec.valid);
				if (!n.rej) chk("op", n.op, exec.op);
				if (!n.rej && n.chk) chk("addr", n.addr, exec.addr);
				if (!n.rej && n.op == 3'h0) chk("data", n.data, exec.data);
			end
		end
	end
	initial begin
		#2000000;
		chk("watchdog", 0, 1);
		summarize();
	end
	initial begin
		seed = 32'h1DDA;
		rst_n = 1'b0;
		wp_n = 1'b1;
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		for (int i = 0; i < 100 && ready !== 1'b1; i++) @(posedge clk);
		#1;
		chk("ready", 1, ready);
		chk("status", 8'h00, status);
		chk("data", 8'hFF, exec.data);
		cmd({8'h02, 24'h000100, 8'h55, 24'h0}, 40, 1, 0, 0);
		cmd({8'h06, 56'h0}, 8, 0, 7, 0);
		cmd({8'h06, 56'h0}, 9, 1, 0, 0);
		chk("wel", 1, write_enable_latch);
		cmd({8'h02, 24'h001000, 8'hAA, 24'h0}, 40, 0, 0, 1);
		chk("wel", 0, write_enable_latch);
		cmd({8'h06, 56'h0}, 8, 0, 7, 0);
		chk("wel", 1, write_enable_latch);
		cmd({sfwp_pkg::CMD_CLR_WEL, 56'h0}, 8, 0, 7, 0);
		chk("wel", 0, write_enable_latch);
		cmd({8'h03, 56'h0}, 32, 1, 0, 0);
		for (int i = 0; i < 5; i++) begin
			a = 24'($random(seed)) & 24'h1FFFFF;
			cmd({8'h06, 56'h0}, 8, 0, 7, 0);
			cmd({ec[i], a, 32'h0}, i == 4 ? 8 : 32, 0, 3'(i + 1), i != 4);
		end
		$display("test basic done");
		for (int i = 0; i < 24; i++) begin
			s = 8'($random(seed)) & 8'h3F;
			a = 24'($random(seed)) & 24'h1FFFFF;
			cmd({8'h06, 56'h0}, 8, 0, 7, 0);
			cmd({8'h01, s, 48'h0}, 16, 0, 7, 0);
			chk("status", s, status);
			cmd({8'h06, 56'h0}, 8, 0, 7, 0);
			cmd({8'h02, a, 8'h5A, 24'h0}, 40, prot(s, a), 0, 1);
		end
		$display("test protection done");
		wp_n = 1'b0;
		cmd({8'h06, 56'h0}, 8, 0, 7, 0);
		cmd({8'h01, 8'hFF, 48'h0}, 16, 0, 7, 0);
		chk("status", (s & 8'hDF) | 8'h20, status);
		wp_n = 1'b1;
		cmd({8'h06, 56'h0}, 8, 0, 7, 0);
		cmd({sfwp_pkg::CMD_DEEP_DOWN, 56'h0}, 8, 0, 7, 0);
		chk("deep", 1, deep);
		cmd({8'h06, 56'h0}, 8, 1, 0, 0);
		cmd({sfwp_pkg::CMD_RELEASE, 56'h0}, 8, 0, 7, 0);
		chk("deep", 0, deep);
		$display("test write protect and deep done");
		rst_n = 1'b0;
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		chk("status", 8'h00, status);
		cmd({8'h06, 56'h0}, 8, 0, 7, 0);
		chk("wel", 0, write_enable_latch);
		chk("pending", 0, q.size());
		$display("test second reset done");
		summarize();
	end
endmodule
